// ===== common/gpr_mem_if.sv
// request and read-data bundle between the register map and its general-purpose ram
// assumes one clock; read data appear one edge after an enabled read
`timescale 1ns/1ns
interface gpr_mem_if #(parameter int AW = 8, parameter int DW = 8);
	logic          en;
	logic          we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;

	modport ctrl  (output en, output we, output addr, output wdata, input rdata);
	modport store (input en, input we, input addr, input wdata, output rdata);
endinterface : gpr_mem_if

// ===== common/sfr_pkg.sv
// constants for the bank 2 / bank 3 special-function register map
// assumes an 8-bit data memory of 9-bit addresses, reached over a 32-bit apb slave
package sfr_pkg;
	localparam int APB_AW = 12;
	localparam int DM_AW  = 9;
	localparam int FILE_W = 7;
	localparam int FILE_LSB = 2;
	localparam int FILE_MSB = 8;
	localparam int PC_HIGH_W = 5;
	localparam int PM_DATA_HIGH_W = 6;
	localparam int PM_ADDR_HIGH_W = 5;
	localparam int GPR_AW = 8;

	typedef logic [DM_AW-1:0] dm_addr_t;

	// register indices: byte address on the bus is four times the low seven index bits
	localparam dm_addr_t IDX_INDIRECT_PORT_B2   = 9'h100;
	localparam dm_addr_t IDX_TIMER0_COUNT       = 9'h101;
	localparam dm_addr_t IDX_PC_LOW_B2          = 9'h102;
	localparam dm_addr_t IDX_STATUS_B2          = 9'h103;
	localparam dm_addr_t IDX_POINTER_B2         = 9'h104;
	localparam dm_addr_t IDX_SECOND_IO_PORT     = 9'h106;
	localparam dm_addr_t IDX_PC_HIGH_LATCH_B2   = 9'h10A;
	localparam dm_addr_t IDX_INT_CONTROL_B2     = 9'h10B;
	localparam dm_addr_t IDX_PM_DATA_LOW        = 9'h10C;
	localparam dm_addr_t IDX_PM_ADDR_LOW        = 9'h10D;
	localparam dm_addr_t IDX_PM_DATA_HIGH       = 9'h10E;
	localparam dm_addr_t IDX_PM_ADDR_HIGH       = 9'h10F;
	localparam dm_addr_t IDX_INDIRECT_PORT_B3   = 9'h180;
	localparam dm_addr_t IDX_OPTIONS            = 9'h181;
	localparam dm_addr_t IDX_PC_LOW_B3          = 9'h182;
	localparam dm_addr_t IDX_STATUS_B3          = 9'h183;
	localparam dm_addr_t IDX_POINTER_B3         = 9'h184;
	localparam dm_addr_t IDX_SECOND_PORT_DIR    = 9'h186;
	localparam dm_addr_t IDX_PC_HIGH_LATCH_B3   = 9'h18A;
	localparam dm_addr_t IDX_INT_CONTROL_B3     = 9'h18B;
	localparam dm_addr_t IDX_PM_CONTROL         = 9'h18C;
	localparam dm_addr_t IDX_RSVD_A             = 9'h18E;
	localparam dm_addr_t IDX_RSVD_B             = 9'h18F;
	localparam dm_addr_t GPR_B2_LO              = 9'h110;
	localparam dm_addr_t GPR_B2_HI              = 9'h16F;
	localparam dm_addr_t GPR_B3_LO              = 9'h190;
	localparam dm_addr_t GPR_B3_HI              = 9'h1EF;

	// reset values
	localparam logic [7:0] RST_STATUS_POR   = 8'h18;
	localparam logic [7:0] RST_OPTIONS      = 8'hFF;
	localparam logic [7:0] RST_PORT_DIR     = 8'hFF;
	localparam logic [7:0] RST_BYTE         = 8'h00;
	localparam logic [4:0] RST_PC_HIGH      = 5'h00;
	localparam logic [7:0] INTERRUPT_CONTROL_KEEP_MASK = 8'h01;

	// status fields
	localparam int ST_IRP = 7;
	localparam int ST_RP_HI = 6;
	localparam int ST_RP_LO = 5;
	localparam int ST_TO = 4;
	localparam int ST_PD = 3;
	localparam logic [7:0] STATUS_WR_MASK   = 8'hE7;
	localparam logic [7:0] STATUS_BANK_MASK = 8'hE0;

	// program-memory control fields
	localparam int PMC_ONE_BIT = 7;
	localparam int PMC_RD_BIT  = 0;

	typedef enum logic [1:0] {APB_IDLE, APB_WAIT, APB_DONE} apb_phase_e;

	typedef enum logic [4:0] {
		SEL_NONE, SEL_INDIRECT, SEL_TIMER0, SEL_PC_LOW, SEL_STATUS, SEL_POINTER,
		SEL_PORT, SEL_PC_LATCH, SEL_INTERRUPT_CONTROL, SEL_PMDL, SEL_PMAL, SEL_PMDH, SEL_PMAH,
		SEL_OPTIONS, SEL_PORT_DIR, SEL_PMCON, SEL_GPR
	} reg_sel_e;
endpackage : sfr_pkg

// ===== design/gpr_mem.sv
// general-purpose ram of banks 2 and 3, single port, registered read data
// assumes the controller holds en high for exactly the cycle of each access
`timescale 1ns/1ns
module gpr_mem
	import sfr_pkg::*;
#(
	parameter int AW = GPR_AW,
	parameter int DW = 8
)(
	input  wire logic pclk,
	input  wire logic presetn,
	gpr_mem_if.store  port
);
	logic [DW-1:0] mem_q [(1<<AW)];

	// array has no reset: contents are undefined until written
	always_ff @(posedge pclk)
	begin
		if (port.en && port.we)
			mem_q[port.addr] <= port.wdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			port.rdata <= '0;
		else if (port.en && !port.we)
			port.rdata <= mem_q[port.addr];
	end
endmodule : gpr_mem

// ===== design/sfr_bank2_bank3_map.sv
// special-function register decode of data-memory banks 2 and 3, apb slave side
// assumes pins are asynchronous, other_reset and core strobes come from pclk logic
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns

// Summary of operation
// - core registers decode identically in every bank
// - pc high only loaded from latch, on branch or pc low write
// - unimplemented locations and bits read zero, ignore writes
// - port write hits latch, read returns pins
// - fourth/fifth ports absent here, read zero
// - program-memory control top bit reads one
// - power-up and other resets load different values
// - status bank bits choose the decoded bank
module sfr_bank2_bank3_map
	import sfr_pkg::*;
(
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [APB_AW-1:0]         paddr,
	input  wire logic [31:0]               pwdata,
	input  wire logic [3:0]                pstrb,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      other_reset,
	input  wire logic                      branch_taken,
	input  wire logic [7:0]                branch_low,
	output logic      [PC_HIGH_W+7:0]      pc_out,
	input  wire logic                      status_to_pd_load,
	input  wire logic [1:0]                status_to_pd_d,
	input  wire logic                      progmem_read_done,
	input  wire logic [PM_DATA_HIGH_W+7:0] progmem_data_in,
	output logic                           progmem_read_req,
	output logic      [PM_ADDR_HIGH_W+7:0] progmem_addr_out,
	input  wire logic [7:0]                port_pins,
	output logic      [7:0]                port_latch_out,
	output logic      [7:0]                port_dir_out,
	output logic      [7:0]                options_out,
	output logic      [7:0]                int_control_out
);
	apb_phase_e                state_q;
	reg_sel_e                  sel;
	logic [FILE_W-1:0]         file_addr;
	dm_addr_t                  eff_addr;
	logic                      addr_err;
	logic                      wr_fire;
	logic [7:0]                wd;
	logic [7:0]                rd_val;
	logic [31:0]               prdata_q;
	logic [7:0]                status_q;
	logic [7:0]                pointer_q;
	logic [7:0]                pc_low_q;
	logic [PC_HIGH_W-1:0]      pc_high_q;
	logic [PC_HIGH_W-1:0]      pc_latch_q;
	logic [7:0]                interrupt_control_q;
	logic [7:0]                options_q;
	logic [7:0]                port_dir_q;
	logic [7:0]                port_latch_q;
	logic [7:0]                timer0_q;
	logic [7:0]                pm_data_low_q;
	logic [7:0]                pm_addr_low_q;
	logic [PM_DATA_HIGH_W-1:0] pm_data_high_q;
	logic [PM_ADDR_HIGH_W-1:0] pm_addr_high_q;
	logic                      pm_rd_q;
	logic [7:0]                pins_meta_q;
	logic [7:0]                pins_sync_q;

	gpr_mem_if #(.AW(GPR_AW), .DW(8)) gpr ();

	gpr_mem #(.AW(GPR_AW), .DW(8)) gpr_mem_i (
		.pclk    (pclk),
		.presetn (presetn),
		.port    (gpr.store)
	);

	function automatic logic is_mirror(input logic [FILE_W-1:0] off);
		return off == IDX_INDIRECT_PORT_B2[FILE_W-1:0] || off == IDX_PC_LOW_B2[FILE_W-1:0] ||
			off == IDX_STATUS_B2[FILE_W-1:0] || off == IDX_POINTER_B2[FILE_W-1:0] ||
			off == IDX_PC_HIGH_LATCH_B2[FILE_W-1:0] || off == IDX_INT_CONTROL_B2[FILE_W-1:0];
	endfunction : is_mirror

	function automatic reg_sel_e decode(input dm_addr_t a);
		reg_sel_e s;
		s = SEL_NONE;
		if (is_mirror(a[FILE_W-1:0]))
		begin
			// same physical register whatever the bank bits say
			case (a[FILE_W-1:0])
				IDX_INDIRECT_PORT_B2[FILE_W-1:0]:  s = SEL_INDIRECT;
				IDX_PC_LOW_B2[FILE_W-1:0]:         s = SEL_PC_LOW;
				IDX_STATUS_B2[FILE_W-1:0]:         s = SEL_STATUS;
				IDX_POINTER_B2[FILE_W-1:0]:        s = SEL_POINTER;
				IDX_PC_HIGH_LATCH_B2[FILE_W-1:0]:  s = SEL_PC_LATCH;
				default:                           s = SEL_INTERRUPT_CONTROL;
			endcase
		end
		else if (a[DM_AW-1])
		begin
			case (a)
				IDX_TIMER0_COUNT:    s = SEL_TIMER0;
				IDX_SECOND_IO_PORT:  s = SEL_PORT;
				IDX_PM_DATA_LOW:     s = SEL_PMDL;
				IDX_PM_ADDR_LOW:     s = SEL_PMAL;
				IDX_PM_DATA_HIGH:    s = SEL_PMDH;
				IDX_PM_ADDR_HIGH:    s = SEL_PMAH;
				IDX_OPTIONS:         s = SEL_OPTIONS;
				IDX_SECOND_PORT_DIR: s = SEL_PORT_DIR;
				IDX_PM_CONTROL:      s = SEL_PMCON;
				IDX_RSVD_A, IDX_RSVD_B: s = SEL_NONE;
				default:
				begin
					if ((a >= GPR_B2_LO && a <= GPR_B2_HI) || (a >= GPR_B3_LO && a <= GPR_B3_HI))
						s = SEL_GPR;
					else
						s = SEL_NONE;
				end
			endcase
		end
		else
			s = SEL_NONE;
		return s;
	endfunction : decode

	// direct access takes the bank from status; file zero goes through the pointer
	always_comb
	begin
		file_addr = paddr[FILE_MSB:FILE_LSB];
		addr_err = (paddr[FILE_LSB-1:0] != '0) || (paddr[APB_AW-1:FILE_MSB+1] != '0);
		if (file_addr == IDX_INDIRECT_PORT_B2[FILE_W-1:0])
			eff_addr = {status_q[ST_IRP], pointer_q};
		else
			eff_addr = {status_q[ST_RP_HI:ST_RP_LO], file_addr};
		sel = addr_err ? SEL_NONE : decode(eff_addr);
	end

	assign pready   = (state_q == APB_DONE);
	assign pslverr  = pready && addr_err;
	assign prdata   = prdata_q;
	assign wd       = pwdata[7:0];
	assign wr_fire  = psel && penable && pready && pwrite && pstrb[0] && !addr_err;

	// one wait state gives the ram its registered read before prdata is captured
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= APB_IDLE;
		else
		begin
			case (state_q)
				APB_IDLE: if (psel && !penable) state_q <= APB_WAIT;
				APB_WAIT: state_q <= APB_DONE;
				APB_DONE: state_q <= APB_IDLE;
				default:  state_q <= APB_IDLE;
			endcase
		end
	end

	assign gpr.en    = (sel == SEL_GPR) && ((state_q == APB_IDLE && psel && !penable && !pwrite) || wr_fire);
	assign gpr.we    = wr_fire;
	assign gpr.addr  = eff_addr[GPR_AW-1:0];
	assign gpr.wdata = wd;

	always_comb
	begin
		case (sel)
			SEL_TIMER0:   rd_val = timer0_q;
			SEL_PC_LOW:   rd_val = pc_low_q;
			SEL_STATUS:   rd_val = status_q;
			SEL_POINTER:  rd_val = pointer_q;
			SEL_PORT:     rd_val = pins_sync_q;
			SEL_PC_LATCH: rd_val = {3'h0, pc_latch_q};
			SEL_INTERRUPT_CONTROL:   rd_val = interrupt_control_q;
			SEL_PMDL:     rd_val = pm_data_low_q;
			SEL_PMAL:     rd_val = pm_addr_low_q;
			SEL_PMDH:     rd_val = {2'h0, pm_data_high_q};
			SEL_PMAH:     rd_val = {3'h0, pm_addr_high_q};
			SEL_OPTIONS:  rd_val = options_q;
			SEL_PORT_DIR: rd_val = port_dir_q;
			SEL_PMCON:    rd_val = {1'b1, 6'h00, pm_rd_q};
			SEL_GPR:      rd_val = gpr.rdata;
			default:      rd_val = RST_BYTE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= '0;
		else if (state_q == APB_WAIT)
			prdata_q <= {24'h000000, rd_val};
	end

	// pins are asynchronous: two flops before anything looks at them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pins_meta_q <= RST_BYTE;
			pins_sync_q <= RST_BYTE;
		end
		else
		begin
			pins_meta_q <= port_pins;
			pins_sync_q <= pins_meta_q;
		end
	end

	// time-out and power-down flags are read-only to software
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_q <= RST_STATUS_POR;
		else
		begin
			if (other_reset)
				status_q <= status_q & ~STATUS_BANK_MASK;
			else if (wr_fire && sel == SEL_STATUS)
				status_q <= (status_q & ~STATUS_WR_MASK) | (wd & STATUS_WR_MASK);
			if (status_to_pd_load)
				{status_q[ST_TO], status_q[ST_PD]} <= status_to_pd_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pointer_q <= RST_BYTE;
		else if (wr_fire && sel == SEL_POINTER)
			pointer_q <= wd;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pc_latch_q <= RST_PC_HIGH;
		else if (other_reset)
			pc_latch_q <= RST_PC_HIGH;
		else if (wr_fire && sel == SEL_PC_LATCH)
			pc_latch_q <= wd[PC_HIGH_W-1:0];
	end

	// the upper pc bits move only through the latch, never from the bus directly
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pc_low_q  <= RST_BYTE;
			pc_high_q <= RST_PC_HIGH;
		end
		else if (other_reset)
		begin
			pc_low_q  <= RST_BYTE;
			pc_high_q <= RST_PC_HIGH;
		end
		else if (branch_taken)
		begin
			pc_low_q  <= branch_low;
			pc_high_q <= pc_latch_q;
		end
		else if (wr_fire && sel == SEL_PC_LOW)
		begin
			pc_low_q  <= wd;
			pc_high_q <= pc_latch_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			interrupt_control_q <= RST_BYTE;
		else if (other_reset)
			interrupt_control_q <= interrupt_control_q & INTERRUPT_CONTROL_KEEP_MASK;
		else if (wr_fire && sel == SEL_INTERRUPT_CONTROL)
			interrupt_control_q <= wd;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			options_q  <= RST_OPTIONS;
			port_dir_q <= RST_PORT_DIR;
		end
		else if (other_reset)
		begin
			options_q  <= RST_OPTIONS;
			port_dir_q <= RST_PORT_DIR;
		end
		else if (wr_fire && sel == SEL_OPTIONS)
			options_q <= wd;
		else if (wr_fire && sel == SEL_PORT_DIR)
			port_dir_q <= wd;
	end

	// port latch and timer keep their value across a non power-up reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port_latch_q <= RST_BYTE;
			timer0_q     <= RST_BYTE;
		end
		else if (wr_fire && sel == SEL_PORT)
			port_latch_q <= wd;
		else if (wr_fire && sel == SEL_TIMER0)
			timer0_q <= wd;
	end

	// a completed program-memory read overrides a bus write to the data bytes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pm_data_low_q  <= RST_BYTE;
			pm_data_high_q <= '0;
			pm_addr_low_q  <= RST_BYTE;
			pm_addr_high_q <= '0;
		end
		else
		begin
			if (progmem_read_done)
			begin
				pm_data_low_q  <= progmem_data_in[7:0];
				pm_data_high_q <= progmem_data_in[PM_DATA_HIGH_W+7:8];
			end
			else if (wr_fire && sel == SEL_PMDL)
				pm_data_low_q <= wd;
			else if (wr_fire && sel == SEL_PMDH)
				pm_data_high_q <= wd[PM_DATA_HIGH_W-1:0];
			if (wr_fire && sel == SEL_PMAL)
				pm_addr_low_q <= wd;
			if (wr_fire && sel == SEL_PMAH)
				pm_addr_high_q <= wd[PM_ADDR_HIGH_W-1:0];
		end
	end

	// software only sets the read request; a set in the done cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pm_rd_q <= 1'b0;
		else if (other_reset)
			pm_rd_q <= 1'b0;
		else if (wr_fire && sel == SEL_PMCON && wd[PMC_RD_BIT])
			pm_rd_q <= 1'b1;
		else if (progmem_read_done)
			pm_rd_q <= 1'b0;
	end

	assign pc_out           = {pc_high_q, pc_low_q};
	assign progmem_read_req = pm_rd_q;
	assign progmem_addr_out = {pm_addr_high_q, pm_addr_low_q};
	assign port_latch_out   = port_latch_q;
	assign port_dir_out     = port_dir_q;
	assign options_out      = options_q;
	assign int_control_out  = interrupt_control_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	mirror_status_a: assert property ((state_q == APB_WAIT && file_addr == IDX_STATUS_B2[FILE_W-1:0] && !addr_err)
		|-> sel == SEL_STATUS) else $error("status not mirrored");
	pc_branch_a: assert property (branch_taken && !other_reset |=> pc_out == {$past(pc_latch_q), $past(branch_low)})
		else $error("branch did not load pc from latch");
	pc_hold_a: assert property (!branch_taken && !other_reset && !(wr_fire && sel == SEL_PC_LOW)
		|=> $stable(pc_high_q)) else $error("pc high moved without branch");
	unimpl_zero_a: assert property (state_q == APB_WAIT && sel == SEL_NONE |=> prdata == 32'h00000000)
		else $error("unimplemented location read nonzero");
	port_pins_a: assert property (state_q == APB_WAIT && sel == SEL_PORT |=> prdata[7:0] == $past(pins_sync_q))
		else $error("port read did not return pins");
	pmcon_msb_a: assert property (state_q == APB_WAIT && sel == SEL_PMCON |=> prdata[7])
		else $error("program control top bit read zero");
	other_reset_a: assert property (other_reset && !status_to_pd_load
		|=> status_q[ST_RP_HI:ST_RP_LO] == 2'h0 && status_q[ST_TO] == $past(status_q[ST_TO]) && options_q == RST_OPTIONS)
		else $error("non power-up reset values wrong");
	bank_select_a: assert property (psel && !penable && file_addr != '0
		|-> eff_addr[DM_AW-1:FILE_W] == status_q[ST_RP_HI:ST_RP_LO]) else $error("bank bits ignored");
	indirect_path_a: assert property (psel && file_addr == '0 |-> eff_addr == {status_q[ST_IRP], pointer_q})
		else $error("indirect address wrong");
	one_wait_a: assert property (state_q == APB_IDLE && psel && !penable |=> !pready ##1 pready)
		else $error("answer timing wrong");

	port_read_c: cover property (state_q == APB_DONE && psel && !pwrite && sel == SEL_PORT);
	branch_c: cover property (wr_fire && sel == SEL_PC_LATCH ##[1:20] branch_taken);
	indirect_gpr_c: cover property (wr_fire && file_addr == '0 && sel == SEL_GPR);
endmodule : sfr_bank2_bank3_map

// ===== tb/core_access_model.sv
// cpu-core side of the data-memory path, acting as the apb master of the register map
// assumes callers enter xfer right after a clock edge; the bench watchdog cuts a hang
`timescale 1ns/1ns
module core_access_model
	import sfr_pkg::*;
(
	input  wire logic              pclk,
	output logic                   psel,
	output logic                   penable,
	output logic                   pwrite,
	output logic      [APB_AW-1:0] paddr,
	output logic      [31:0]       pwdata,
	output logic      [3:0]        pstrb,
	input  wire logic [31:0]       prdata,
	input  wire logic              pready,
	input  wire logic              pslverr
);
	initial
	begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0;
		pstrb   = 4'h0;
	end

	// one whole transfer; the slave decides the wait, so none is assumed here
	// slave-port interrupt bits sit outside banks 2/3, this core never sets them
	task automatic xfer(input logic wr, input logic [APB_AW-1:0] a, input logic [7:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {24'h0, d};
		pstrb   <= 4'hF;
		@(posedge pclk);
		penable <= 1'b1;
		// request stands until the rising edge at which pready is seen high
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// let the completion edge land before anyone samples
		@(negedge pclk);
	endtask : xfer
endmodule : core_access_model

// ===== tb/sfr_bank2_bank3_map_tb.sv
// self-checking bench for the bank 2 / bank 3 register map
// assumes core_access_model as bus master; the bench drives pins and core strobes
`timescale 1ns/1ns
module sfr_bank2_bank3_map_tb
	import sfr_pkg::*;
;
	logic                      pclk;
	logic                      presetn;
	logic                      psel;
	logic                      penable;
	logic                      pwrite;
	logic [APB_AW-1:0]         paddr;
	logic [31:0]               pwdata;
	logic [3:0]                pstrb;
	logic [31:0]               prdata;
	logic                      pready;
	logic                      pslverr;
	logic                      other_reset;
	logic                      branch_taken;
	logic [7:0]                branch_low;
	logic [PC_HIGH_W+7:0]      pc_out;
	logic                      status_to_pd_load;
	logic [1:0]                status_to_pd_d;
	logic                      progmem_read_done;
	logic [PM_DATA_HIGH_W+7:0] progmem_data_in;
	logic                      progmem_read_req;
	logic [PM_ADDR_HIGH_W+7:0] progmem_addr_out;
	logic [7:0]                port_pins;
	logic [7:0]                port_latch_out;
	logic [7:0]                port_dir_out;
	logic [7:0]                options_out;
	logic [7:0]                int_control_out;
	logic [31:0]               bus_rd;
	logic                      bus_err;
	int                        fails;
	int                        samples_checked;

	sfr_bank2_bank3_map sfr_bank2_bank3_map_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .other_reset, .branch_taken, .branch_low,
		.pc_out, .status_to_pd_load, .status_to_pd_d, .progmem_read_done, .progmem_data_in,
		.progmem_read_req, .progmem_addr_out, .port_pins, .port_latch_out, .port_dir_out,
		.options_out, .int_control_out);

	core_access_model core_access_model_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr);

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic finish_test;
		if (fails == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk

	// bus address is four times the low seven index bits; the bank comes from status
	task automatic wr(input dm_addr_t a, input logic [7:0] d);
		core_access_model_i.xfer(1'b1, {3'h0, a[6:0], 2'h0}, d, bus_rd, bus_err);
	endtask : wr

	task automatic rd(input string n, input dm_addr_t a, input logic [7:0] x);
		core_access_model_i.xfer(1'b0, {3'h0, a[6:0], 2'h0}, 8'h00, bus_rd, bus_err);
		chk(n, bus_rd, {24'h0, x});
	endtask : rd

	task automatic t_reset;
		rd("status", IDX_STATUS_B2, 8'h18);
		rd("latch", IDX_PC_HIGH_LATCH_B2, 8'h00);
		rd("interrupt_control", IDX_INT_CONTROL_B2, 8'h00);
		chk("opt_out", 32'(options_out), 32'hFF);
		chk("pc_out", 32'(pc_out), 32'h0);
		wr(IDX_STATUS_B2, 8'h60);
		rd("status_b3", IDX_STATUS_B3, 8'h78);
		rd("options", IDX_OPTIONS, 8'hFF);
		rd("dir", IDX_SECOND_PORT_DIR, 8'hFF);
		rd("pmcon", IDX_PM_CONTROL, 8'h80);
		rd("rsvd_a", IDX_RSVD_A, 8'h00);
	endtask : t_reset

	task automatic t_mirror;
		wr(IDX_POINTER_B3, 8'h5A);
		wr(IDX_PC_HIGH_LATCH_B3, 8'h0C);
		wr(IDX_STATUS_B3, 8'h40);
		rd("ptr_b2", IDX_POINTER_B2, 8'h5A);
		rd("latch_b2", IDX_PC_HIGH_LATCH_B2, 8'h0C);
		rd("status_b2", IDX_STATUS_B2, 8'h58);
		wr(IDX_TIMER0_COUNT, 8'h33);
		rd("timer0", IDX_TIMER0_COUNT, 8'h33);
		wr(IDX_STATUS_B2, 8'h00);
		rd("timer0_b0", IDX_TIMER0_COUNT, 8'h00);
		rd("ptr_b0", IDX_POINTER_B2, 8'h5A);
		rd("port4", 9'h008, 8'h00);
		wr(IDX_STATUS_B2, 8'h20);
		rd("dir4", 9'h088, 8'h00);
		rd("dir5", 9'h089, 8'h00);
	endtask : t_mirror

	task automatic t_unimpl;
		wr(IDX_STATUS_B2, 8'h40);
		wr(9'h105, 8'hFF);
		rd("loc105", 9'h105, 8'h00);
		wr(IDX_PC_HIGH_LATCH_B2, 8'hFF);
		rd("latch_bits", IDX_PC_HIGH_LATCH_B2, 8'h1F);
		wr(IDX_PM_DATA_HIGH, 8'hFF);
		rd("pmdh_bits", IDX_PM_DATA_HIGH, 8'h3F);
		// an out-of-range write aimed at the latch must be refused
		core_access_model_i.xfer(1'b1, 12'h228, 8'h05, bus_rd, bus_err);
		chk("err_wr", 32'(bus_err), 32'h1);
		core_access_model_i.xfer(1'b0, 12'h00D, 8'h00, bus_rd, bus_err);
		chk("err_rd", {bus_rd[31:1], bus_err}, 32'h1);
		rd("latch_kept", IDX_PC_HIGH_LATCH_B2, 8'h1F);
		wr(IDX_STATUS_B2, 8'h60);
		wr(9'h18D, 8'hFF);
		rd("loc18d", 9'h18D, 8'h00);
		rd("rsvd_b", IDX_RSVD_B, 8'h00);
	endtask : t_unimpl

	task automatic t_port;
		@(posedge pclk);
		port_pins <= 8'hA5;
		wr(IDX_STATUS_B3, 8'h40);
		wr(IDX_SECOND_IO_PORT, 8'h3C);
		chk("latch_out", 32'(port_latch_out), 32'h3C);
		rd("pins", IDX_SECOND_IO_PORT, 8'hA5);
		wr(IDX_STATUS_B2, 8'h60);
		wr(IDX_SECOND_PORT_DIR, 8'h0F);
		chk("dir_out", 32'(port_dir_out), 32'h0F);
	endtask : t_port

	task automatic t_pc;
		wr(IDX_PC_HIGH_LATCH_B3, 8'h15);
		chk("pc_hold", 32'(pc_out), 32'h0);
		@(posedge pclk);
		branch_taken <= 1'b1;
		branch_low   <= 8'h42;
		@(posedge pclk);
		branch_taken <= 1'b0;
		@(negedge pclk);
		chk("pc_branch", 32'(pc_out), 32'h1542);
		rd("pc_low", IDX_PC_LOW_B3, 8'h42);
		wr(IDX_PC_HIGH_LATCH_B3, 8'h03);
		wr(IDX_PC_LOW_B3, 8'h10);
		chk("pc_write", 32'(pc_out), 32'h0310);
	endtask : t_pc

	task automatic t_indirect;
		wr(IDX_STATUS_B3, 8'h40);
		wr(9'h120, 8'h77);
		wr(IDX_POINTER_B2, 8'h20);
		rd("ind_irp0", IDX_INDIRECT_PORT_B2, 8'h00);
		wr(IDX_STATUS_B2, 8'hC0);
		rd("ind_rd", IDX_INDIRECT_PORT_B2, 8'h77);
		wr(IDX_INDIRECT_PORT_B2, 8'h99);
		rd("ind_wr", 9'h120, 8'h99);
		wr(IDX_POINTER_B2, 8'h00);
		wr(IDX_INDIRECT_PORT_B2, 8'h55);
		rd("ind_self", IDX_INDIRECT_PORT_B2, 8'h00);
	endtask : t_indirect

	task automatic t_other;
		wr(IDX_STATUS_B2, 8'h65);
		wr(IDX_OPTIONS, 8'h12);
		wr(IDX_INT_CONTROL_B3, 8'hFF);
		wr(IDX_POINTER_B3, 8'h44);
		chk("int_set", 32'(int_control_out), 32'hFF);
		@(posedge pclk);
		other_reset <= 1'b1;
		@(posedge pclk);
		other_reset <= 1'b0;
		@(negedge pclk);
		chk("opt_rst", 32'(options_out), 32'hFF);
		chk("int_rst", 32'(int_control_out), 32'h01);
		chk("dir_rst", 32'(port_dir_out), 32'hFF);
		chk("latch_kept", 32'(port_latch_out), 32'h3C);
		chk("pc_rst", 32'(pc_out), 32'h0);
		rd("status_rst", IDX_STATUS_B2, 8'h1D);
		rd("ptr_kept", IDX_POINTER_B2, 8'h44);
		rd("latch_rst", IDX_PC_HIGH_LATCH_B2, 8'h00);
		@(posedge pclk);
		status_to_pd_load <= 1'b1;
		status_to_pd_d    <= 2'h1;
		@(posedge pclk);
		status_to_pd_load <= 1'b0;
		rd("status_pd", IDX_STATUS_B2, 8'h0D);
	endtask : t_other

	task automatic t_progmem;
		wr(IDX_STATUS_B2, 8'h45);
		wr(IDX_PM_ADDR_LOW, 8'hAB);
		wr(IDX_PM_ADDR_HIGH, 8'hFF);
		chk("pm_addr", 32'(progmem_addr_out), 32'h1FAB);
		wr(IDX_STATUS_B2, 8'h60);
		wr(IDX_PM_CONTROL, 8'h01);
		chk("rd_req", 32'(progmem_read_req), 32'h1);
		rd("pmcon_rd", IDX_PM_CONTROL, 8'h81);
		@(posedge pclk);
		progmem_read_done <= 1'b1;
		progmem_data_in   <= 14'h3ABC;
		@(posedge pclk);
		progmem_read_done <= 1'b0;
		rd("pmcon_idle", IDX_PM_CONTROL, 8'h80);
		wr(IDX_PM_CONTROL, 8'h00);
		rd("pmcon_w0", IDX_PM_CONTROL, 8'h80);
		wr(IDX_STATUS_B3, 8'h40);
		rd("pm_dl", IDX_PM_DATA_LOW, 8'hBC);
		rd("pm_dh", IDX_PM_DATA_HIGH, 8'h3A);
	endtask : t_progmem

	// whole run is a few hundred cycles, so this limit only trips on a hang
	initial
	begin
		repeat (5000) @(posedge pclk);
		fails++;
		finish_test();
	end

	initial
	begin
		fails             = 0;
		samples_checked   = 0;
		presetn           = 1'b0;
		other_reset       = 1'b0;
		branch_taken      = 1'b0;
		branch_low        = 8'h00;
		status_to_pd_load = 1'b0;
		status_to_pd_d    = 2'h3;
		progmem_read_done = 1'b0;
		progmem_data_in   = 14'h0000;
		port_pins         = 8'h00;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_mirror();
		t_unimpl();
		t_port();
		t_pc();
		t_indirect();
		t_other();
		t_progmem();
		finish_test();
	end
endmodule : sfr_bank2_bank3_map_tb
